// ### shared/lmr_pkg.sv
// Package for the LED matrix refresh and brightness block.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package lmr_pkg;
    localparam int unsigned COL_COUNT        = 20;
    localparam int unsigned ROW_COUNT        = 8;
    localparam int unsigned DOT_BITS         = COL_COUNT * ROW_COUNT;
    localparam int unsigned SLOT_CYCLES      = 64;
    localparam int unsigned BLANK_CYCLES     = 4;
    localparam int unsigned MAX_ON_CYCLES    = SLOT_CYCLES - BLANK_CYCLES;
    localparam int unsigned PASS_CYCLES      = SLOT_CYCLES * ROW_COUNT;
    localparam int unsigned PRESCALE_DIV     = 8;
    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned INT_OSC_HZ       = 1_000_000;
    localparam int unsigned INT_OSC_DIV      = CLK_HZ / INT_OSC_HZ;

    // Register map on the plain port (byte addresses)
    localparam logic [7:0]  ADDR_BRIGHT      = 8'h00;
    localparam logic [7:0]  ADDR_CLKSEL      = 8'h04;
    localparam logic [7:0]  ADDR_STATUS      = 8'h08;
    localparam logic [7:0]  ADDR_DOT_BASE    = 8'h10;
    localparam int unsigned DOT_WORDS        = 5;

    // Brightness control word fields
    localparam int unsigned PEAK_CURRENT_FIELD_MSB = 5;
    localparam int unsigned PEAK_CURRENT_FIELD_LSB = 4;
    localparam int unsigned PWM_FIELD_MSB          = 3;
    localparam int unsigned PWM_FIELD_LSB          = 0;
    localparam logic [6:0]  BRIGHT_RESET     = 7'h40;

    // PWM on-cycle table, index is pwm field
    localparam logic [5:0] PWM_ON_TABLE [16] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09,
        6'h0B, 6'h0E, 6'h12, 6'h17, 6'h1C, 6'h24, 6'h2D, 6'h3C};

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lmr_bus_type;

    typedef struct packed {
        logic [ROW_COUNT-1:0] row_on;
        logic [COL_COUNT-1:0] col_on;
        logic [1:0]           peak_sel;
    } lmr_drive_type;
endpackage : lmr_pkg

// ### src/lmr_refresh.sv
// Refresh sequencer and brightness control for a 20x8 LED dot matrix.
// Assumes synchronous inputs on clk_i; external oscillator is sampled here.
// Contract
// - Hold 160 dot bits as 20 columns by 8 rows, one per pixel.
// - Energise the eight rows one at a time, never two together.
// - A full pass takes exactly 512 oscillator cycles, then restarts at row 0.
// - Each row stays selected for 64 oscillator cycles.
// - Four blank cycles end each slot before the next row turns on.
// - On-time is at most 60 of 64 cycles; PWM only shortens it.
// - Oscillator selectable internal or external; it steps the refresh counter.
// - Each column picks its bit for the active row, one of eight.
// - At most one LED per column lit, so at most 20 per IC.
// - Peak current and PWM both come from brightness word zero.
// - Peak current in bits 5..4, PWM in bits 3..0.
// - Brightness is peak factor times PWM factor, set independently.
`timescale 1ns/1ps
`default_nettype none
module lmr_refresh (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic [7:0]                    addr_i,
    input  wire logic [31:0]                   wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    input  wire logic                          ext_osc_i,
    output logic      [31:0]                   rdata_o,
    output logic      [lmr_pkg::ROW_COUNT-1:0] row_on_o,
    output logic      [lmr_pkg::COL_COUNT-1:0] col_on_o,
    output logic      [1:0]                    peak_sel_o
);
    lmr_pkg::lmr_bus_type   bus;
    lmr_pkg::lmr_drive_type drive_nxt;
    logic [lmr_pkg::DOT_BITS-1:0] dots_r;
    logic [6:0]  bright_r;
    logic        ext_sel_r;
    logic        prescale_r;
    logic [8:0]  refresh_r;
    logic [5:0]  int_div_r;
    logic [2:0]  pre_div_r;
    logic        ext_q1_r;
    logic        ext_q2_r;
    logic        ext_q3_r;
    logic        osc_tick;
    logic        raw_tick;
    logic        int_tick;
    logic        ext_edge;
    logic [2:0]  row_idx;
    logic [5:0]  slot_cyc;
    logic [5:0]  on_cycles;
    logic        lit_window;
    logic [7:0]  dot_word_idx;
    logic [2:0]  prev_row_r;
    logic [6:0]  row_ticks_r;
    logic [9:0]  pass_ticks_r;
    logic        row_change;
    logic        pass_wrap;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Register map, byte addresses, all words 32 bits wide:
    //   brightness word: bits 6..0 kept, bits 5..4 peak current, bits 3..0 PWM
    //   clock select: bit 0 external source, bit 1 divide-by-eight prescaler
    //   status, read only: bit 11 lit window, bits 8..0 refresh counter
    //   dot store: five words from the dot base, dot index is column*8 plus row
    // Unmapped or unaligned writes are dropped; such reads return zero
    // Bit 6 of the brightness word is stored but has no effect on the scan
    // Software writes: brightness word, clock select, dot store words
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bright_r   <= lmr_pkg::BRIGHT_RESET;
            ext_sel_r  <= 1'b0;
            prescale_r <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == lmr_pkg::ADDR_BRIGHT) begin
                bright_r <= bus.wdata[6:0];
            end
            if (bus.addr == lmr_pkg::ADDR_CLKSEL) begin
                ext_sel_r  <= bus.wdata[0];
                prescale_r <= bus.wdata[1];
            end
        end
    end

    assign dot_word_idx = (bus.addr - lmr_pkg::ADDR_DOT_BASE) >> 2;

    // Dot store, 32 bits per word, last word only 0 bits used above 160
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dots_r <= '0;
        end else if (bus.wr && bus.addr >= lmr_pkg::ADDR_DOT_BASE
                     && dot_word_idx < 8'(lmr_pkg::DOT_WORDS) && bus.addr[1:0] == 2'h0) begin
            dots_r[dot_word_idx*32 +: 32] <= bus.wdata;
        end
    end

    // Read data is valid the cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else if (bus.rd) begin
            if (bus.addr == lmr_pkg::ADDR_BRIGHT) begin
                rdata_o <= {25'h0, bright_r};
            end else if (bus.addr == lmr_pkg::ADDR_CLKSEL) begin
                rdata_o <= {30'h0, prescale_r, ext_sel_r};
            end else if (bus.addr == lmr_pkg::ADDR_STATUS) begin
                rdata_o <= {20'h0, lit_window, 2'h0, refresh_r};
            end else if (bus.addr >= lmr_pkg::ADDR_DOT_BASE
                         && dot_word_idx < 8'(lmr_pkg::DOT_WORDS) && bus.addr[1:0] == 2'h0) begin
                rdata_o <= dots_r[dot_word_idx*32 +: 32];
            end else begin
                rdata_o <= '0; // Unmapped reads as zero
            end
        end else begin
            rdata_o <= '0;
        end
    end

    // Internal oscillator: divide system clock down to 1 MHz
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            int_div_r <= '0;
        end else if (int_div_r == 6'(lmr_pkg::INT_OSC_DIV - 1)) begin
            int_div_r <= '0;
        end else begin
            int_div_r <= int_div_r + 6'h01;
        end
    end
    assign int_tick = (int_div_r == 6'(lmr_pkg::INT_OSC_DIV - 1));

    // External oscillator edge detect; q1 feeds only q2
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ext_q1_r <= 1'b0;
            ext_q2_r <= 1'b0;
            ext_q3_r <= 1'b0;
        end else begin
            ext_q1_r <= ext_osc_i;
            ext_q2_r <= ext_q1_r;
            ext_q3_r <= ext_q2_r;
        end
    end
    assign ext_edge = ext_q2_r && !ext_q3_r;
    assign raw_tick = ext_sel_r ? ext_edge : int_tick;

    // Optional divide by eight; lets a fast external clock be used
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_div_r <= '0;
        end else if (raw_tick) begin
            pre_div_r <= pre_div_r + 3'h1;
        end
    end
    assign osc_tick = raw_tick && (!prescale_r || pre_div_r == 3'(lmr_pkg::PRESCALE_DIV - 1));

    // Refresh counter wraps naturally after 512 ticks
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            refresh_r <= '0;
        end else if (osc_tick) begin
            refresh_r <= refresh_r + 9'h001;
        end
    end
    assign row_idx  = refresh_r[8:6];
    assign slot_cyc = refresh_r[5:0];

    // Scan timing, in oscillator ticks:
    //   ticks 0..59 of a slot may light the row, ticks 60..63 always blank
    //   the PWM table picks how many of the first ticks are lit
    //   eight slots of 64 ticks make one pass of 512 ticks
    // Outputs trail the counter by one system clock; far shorter than a tick,
    // so the lag costs no visible on-time
    // On window: PWM count, capped below the four blank cycles
    assign on_cycles  = lmr_pkg::PWM_ON_TABLE[bright_r[lmr_pkg::PWM_FIELD_MSB:lmr_pkg::PWM_FIELD_LSB]];
    assign lit_window = (slot_cyc < on_cycles)
                        && (slot_cyc < 6'(lmr_pkg::MAX_ON_CYCLES));

    // Drive pattern: one-hot row, column mux picks active row bit
    always_comb begin
        drive_nxt          = '0;
        drive_nxt.peak_sel = bright_r[lmr_pkg::PEAK_CURRENT_FIELD_MSB:lmr_pkg::PEAK_CURRENT_FIELD_LSB];
        if (lit_window) begin
            drive_nxt.row_on = 8'h01 << row_idx;
            for (int c = 0; c < lmr_pkg::COL_COUNT; c++) begin
                drive_nxt.col_on[c] = dots_r[c*lmr_pkg::ROW_COUNT + int'(row_idx)];
            end
        end
    end

    // Registered outputs to the row sinks and column sources
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            row_on_o   <= '0;
            col_on_o   <= '0;
            peak_sel_o <= '0;
        end else begin
            row_on_o   <= drive_nxt.row_on;
            col_on_o   <= drive_nxt.col_on;
            peak_sel_o <= drive_nxt.peak_sel;
        end
    end

    // Checker helper: row seen one clock ago, to spot row changes from outside
    // the counter, so slot and pass lengths are not checked by their own decode
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev_row_r <= '0;
        end else begin
            prev_row_r <= row_idx;
        end
    end
    assign row_change = (row_idx != prev_row_r);
    assign pass_wrap  = row_change && (row_idx == 3'h0);

    // Ticks seen since the row last changed; restarts in the first cycle of a row
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            row_ticks_r <= '0;
        end else if (row_change) begin
            row_ticks_r <= 7'(osc_tick);
        end else begin
            row_ticks_r <= row_ticks_r + 7'(osc_tick);
        end
    end

    // Ticks seen since the scan last returned to row 0
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pass_ticks_r <= '0;
        end else if (pass_wrap) begin
            pass_ticks_r <= 10'(osc_tick);
        end else begin
            pass_ticks_r <= pass_ticks_r + 10'(osc_tick);
        end
    end

    chk_one_row: assert property (@(posedge clk_i) disable iff (reset_i)
        $onehot0(row_on_o)) else $error("more than one row on");
    chk_blank_cols: assert property (@(posedge clk_i) disable iff (reset_i)
        (row_on_o == '0) |-> (col_on_o == '0)) else $error("column lit while blank");
    chk_blank_tail: assert property (@(posedge clk_i) disable iff (reset_i)
        (slot_cyc >= 6'(lmr_pkg::MAX_ON_CYCLES)) |=> (row_on_o == '0)) else $error("lit during blanking");
    chk_row_match: assert property (@(posedge clk_i) disable iff (reset_i)
        lit_window |=> (row_on_o == (8'h01 << $past(row_idx)))) else $error("wrong row");
    chk_pwm_cap: assert property (@(posedge clk_i) disable iff (reset_i)
        (slot_cyc >= on_cycles) |=> (row_on_o == '0)) else $error("pwm exceeded");
    chk_wrap_row: assert property (@(posedge clk_i) disable iff (reset_i)
        (osc_tick && refresh_r == 9'h1FF) |=> (refresh_r == 9'h000)) else $error("no wrap");
    chk_peak_field: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 peak_sel_o == $past(bright_r[5:4])) else $error("peak field wrong");
    chk_col_data: assert property (@(posedge clk_i) disable iff (reset_i)
        lit_window |=> col_on_o[0] == $past(dots_r[int'(row_idx)])) else $error("col0 data");
    chk_ext_step: assert property (@(posedge clk_i) disable iff (reset_i)
        (ext_sel_r && !prescale_r && ext_edge) |=> refresh_r == $past(refresh_r) + 9'h001)
        else $error("ext clock no step");

    // Checks on slot and pass length, measured by the helper counters
    // A row lasts exactly one slot of ticks
    chk_slot_len: assert property (@(posedge clk_i) disable iff (reset_i)
        row_change |-> (row_ticks_r == 7'(lmr_pkg::SLOT_CYCLES))) else $error("slot length wrong");

    // A whole pass lasts exactly the pass length
    chk_pass_len: assert property (@(posedge clk_i) disable iff (reset_i)
        pass_wrap |-> (pass_ticks_r == 10'(lmr_pkg::PASS_CYCLES))) else $error("pass length wrong");

    // Rows advance one at a time in order
    chk_row_order: assert property (@(posedge clk_i) disable iff (reset_i)
        row_change |-> (row_idx == prev_row_r + 3'h1)) else $error("row skipped");

    // Drive outputs are dark straight after reset
    chk_out_reset: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(reset_i) |-> (row_on_o == '0 && col_on_o == '0)) else $error("lit after reset");

    // Read data stands only in the cycle after a read strobe
    chk_rdata_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        !rd_i |=> (rdata_o == '0)) else $error("read data without strobe");

    // Status read returns the counter as it stood at the strobe
    chk_status_read: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_i && addr_i == lmr_pkg::ADDR_STATUS) |=> (rdata_o[8:0] == $past(refresh_r))) else $error("status");

    // Brightness write lands the next cycle
    chk_bright_wr: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == lmr_pkg::ADDR_BRIGHT) |=> (bright_r == $past(wdata_i[6:0]))) else $error("bright write");

    // Peak field reaches its pins two cycles after the write
    chk_peak_follow: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == lmr_pkg::ADDR_BRIGHT) |=> ##1 (peak_sel_o == $past(wdata_i[5:4], 2))) else $error("peak");

    // Clock select write lands the next cycle
    chk_clksel_wr: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == lmr_pkg::ADDR_CLKSEL) |=> (ext_sel_r == $past(wdata_i[0]))) else $error("clksel write");

    // First dot word lands whole
    chk_dot_wr: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == lmr_pkg::ADDR_DOT_BASE) |=> (dots_r[31:0] == $past(wdata_i))) else $error("dot write");

    // Unaligned dot writes leave the store alone
    chk_unaligned: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == lmr_pkg::ADDR_DOT_BASE + 8'h01) |=> $stable(dots_r)) else $error("unaligned write");

    // A lit row never reaches into the blank tail
    chk_lit_limit: assert property (@(posedge clk_i) disable iff (reset_i)
        (row_on_o != '0) |-> ($past(slot_cyc) < 6'(lmr_pkg::MAX_ON_CYCLES))) else $error("lit too long");

    // A lit row stays inside the PWM count
    chk_duty_count: assert property (@(posedge clk_i) disable iff (reset_i)
        (row_on_o != '0) |-> ($past(slot_cyc) < $past(on_cycles))) else $error("duty too long");

    // Each tick steps the counter by exactly one
    chk_step_one: assert property (@(posedge clk_i) disable iff (reset_i)
        osc_tick |=> (refresh_r == $past(refresh_r) + 9'h001)) else $error("counter step");

    // Without a tick the counter holds
    chk_hold_still: assert property (@(posedge clk_i) disable iff (reset_i)
        !osc_tick |=> $stable(refresh_r)) else $error("counter moved");

    // Internal divider never passes its terminal count
    chk_int_div: assert property (@(posedge clk_i) disable iff (reset_i)
        (int_div_r <= 6'(lmr_pkg::INT_OSC_DIV - 1))) else $error("divider overrun");

    // With the prescaler on, only every eighth source tick counts
    chk_pre_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (prescale_r && pre_div_r != 3'(lmr_pkg::PRESCALE_DIV - 1)) |-> !osc_tick) else $error("prescale");

    // Any lit column means exactly one row is on
    chk_col_rows: assert property (@(posedge clk_i) disable iff (reset_i)
        (col_on_o != '0) |-> $onehot(row_on_o)) else $error("column without row");

    // Last column follows its dot for the active row
    chk_col_last: assert property (@(posedge clk_i) disable iff (reset_i)
        lit_window |=> col_on_o[19] == $past(dots_r[19*8 + int'(row_idx)])) else $error("col19 data");

    // Main scenarios reached
    cov_prescale: cover property (@(posedge clk_i) prescale_r && osc_tick);
    cov_lit_full: cover property (@(posedge clk_i) row_on_o != '0 && $past(slot_cyc) == 6'h3B);
    cov_row7: cover property (@(posedge clk_i) row_on_o == 8'h80);
    cov_ext: cover property (@(posedge clk_i) ext_sel_r && osc_tick);
    cov_wrap: cover property (@(posedge clk_i) osc_tick && refresh_r == 9'h1FF);
endmodule : lmr_refresh
`default_nettype wire

// ### verif/lmr_osc_model.sv
// External oscillator source standing at the far side of the refresh block.
// Assumes the bench clock; the source drops low at its next half period once run_i is low.
`timescale 1ns/1ps
`default_nettype none
module lmr_osc_model #(
    parameter int HALF = 30
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      osc_o,
    output logic      tick_o
);
    int cnt_r;
    // Period of 60 clocks gives 833 kHz: above the flicker floor, under the unprescaled ceiling
    always @(posedge clk_i) begin
        cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
        if (cnt_r == HALF - 1) begin
            osc_o <= run_i ? ~osc_o : 1'b0; // Drops low when not running
        end
        tick_o <= (cnt_r == HALF - 1) && run_i && !osc_o;
    end
    // Known start so the first edge is a clean rise
    initial begin
        cnt_r = 0;
        osc_o = 1'b0;
        tick_o = 1'b0;
    end
endmodule : lmr_osc_model
`default_nettype wire

// ### verif/led_matrix_refresh_brightness_bench.sv
// Self-checking bench for the refresh block with a behavioural scan model.
// Assumes the register map and lag of one clock given by the designer.
`timescale 1ns/1ps
`default_nettype none
module led_matrix_refresh_brightness_bench;
    logic         clk_i, reset_i, wr_i, rd_i, run_r, ext_osc, tick, lit_b;
    logic [7:0]   addr_i, row_on_o;
    logic [31:0]  wdata_i, rdata_o, d;
    logic [19:0]  col_on_o, col_x;
    logic [1:0]   peak_sel_o;
    logic [159:0] dots_m;
    logic [6:0]   bright_m;
    int           fails, tests_run, seed, cnt_m, p, n, k, j;
    lmr_refresh dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .ext_osc_i(ext_osc), .rdata_o(rdata_o), .row_on_o(row_on_o), .col_on_o(col_on_o),
        .peak_sel_o(peak_sel_o));
    lmr_osc_model osc_u (.clk_i(clk_i), .run_i(run_r), .osc_o(ext_osc), .tick_o(tick));
    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Waits for an oscillator rise, then lets the synchroniser settle before sampling
    task automatic wait_tick();
        for (j = 0; j < 200 && tick !== 1'b1; j++) begin
            @(posedge clk_i);
            #1;
        end
        if (tick !== 1'b1) begin
            fails++;
            wrap_up();
        end
        repeat (20) @(posedge clk_i);
    endtask : wait_tick
    initial begin
        reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = '0; wdata_i = '0; run_r = 1'b0;
        seed = 36; fails = 0; tests_run = 0; dots_m = '0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(lmr_pkg::ADDR_BRIGHT);  check("bright_rst", d, 32'h00000040);
        rd(lmr_pkg::ADDR_CLKSEL);  check("clksel_rst", d, 32'h00000000);
        rd(8'h0C);                 check("unmapped", d, 32'h00000000);
        // Internal oscillator steps the counter once per 50 clocks
        rd(lmr_pkg::ADDR_STATUS); cnt_m = d[8:0];
        repeat (500) @(posedge clk_i);
        rd(lmr_pkg::ADDR_STATUS);
        check("int_rate", 32'(((d[8:0] - cnt_m) >= 9) && ((d[8:0] - cnt_m) <= 11)), 32'h1);
        // Random dot store, read back word by word
        for (k = 0; k < 5; k++) begin
            d = $random(seed);
            dots_m[32*k +: 32] = d;
            wr(lmr_pkg::ADDR_DOT_BASE + 8'(4 * k), d);
            rd(lmr_pkg::ADDR_DOT_BASE + 8'(4 * k)); check("dot_word", d, dots_m[32*k +: 32]);
        end
        // External source; first rise aligns the model counter
        wr(lmr_pkg::ADDR_CLKSEL, 32'h1);
        run_r <= 1'b1;
        wait_tick();
        rd(lmr_pkg::ADDR_STATUS); cnt_m = d[8:0];
        // Full wrapped pass at maximum PWM, then shorter runs at other settings
        for (k = 0; k < 6; k++) begin
            p = (k == 0) ? 15 : (k == 5) ? 0 : ($random(seed) & 15);
            n = (k == 0) ? 520 : 70;
            bright_m = {1'b1, 2'($random(seed)), 4'(p)};
            wr(lmr_pkg::ADDR_BRIGHT, {25'h0, bright_m});
            rd(lmr_pkg::ADDR_BRIGHT); check("bright", d, {25'h0, bright_m});
            check("peak_sel", peak_sel_o, bright_m[5:4]);
            repeat (n) begin
                wait_tick();
                cnt_m = (cnt_m + 1) % 512;
                lit_b = (cnt_m % 64) < lmr_pkg::PWM_ON_TABLE[p] && (cnt_m % 64) < lmr_pkg::MAX_ON_CYCLES;
                for (j = 0; j < 20; j++) col_x[j] = lit_b & dots_m[j*8 + cnt_m/64];
                rd(lmr_pkg::ADDR_STATUS);
                check("counter", d[8:0], cnt_m);
                check("lit", d[11], lit_b);
                check("col_on", col_on_o, col_x);
                if (lit_b) check("row_on", row_on_o, 8'h01 << (cnt_m / 64));
                else check("row_off", row_on_o, 32'h0);
            end
        end
        // Prescaler on: sixteen source rises must step the counter exactly twice
        wr(lmr_pkg::ADDR_CLKSEL, 32'h3);
        rd(lmr_pkg::ADDR_STATUS); cnt_m = d[8:0];
        repeat (16) wait_tick();
        rd(lmr_pkg::ADDR_STATUS);
        check("prescale", (32'(d[8:0]) + 512 - cnt_m) % 512, 32'h2);
        wrap_up();
    end
endmodule : led_matrix_refresh_brightness_bench
`default_nettype wire
